// ===== hw/tdc_pkg.sv
// shared constants, types and decode function for the test dac control block
package tdc_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ       = 25_000_000;
    localparam int LOSS_TIME_NS = 40_000;
    // longest time, so rounded down
    localparam int LOSS_CYCLES  = (LOSS_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int LOSS_W       = $clog2(LOSS_CYCLES + 1);
    // 2.048 MHz master clock over 256 kHz bitstream rate
    localparam int DIV_RATIO    = 8;
    localparam int DIV_W        = $clog2(DIV_RATIO);

    // ****************************************************************
    // mode and attenuation codes
    // ****************************************************************
    localparam logic [2:0] MODE_SLEEP_LO  = 3'h0;
    localparam logic [2:0] MODE_AC_BOTH   = 3'h1;
    localparam logic [2:0] MODE_AC_OUT    = 3'h2;
    localparam logic [2:0] MODE_AC_BUF    = 3'h3;
    localparam logic [2:0] MODE_DC_COMMON = 3'h4;
    localparam logic [2:0] MODE_DC_DIFF   = 3'h5;
    localparam logic [2:0] MODE_AC_COMMON = 3'h6;
    localparam logic [2:0] MODE_SLEEP_HI  = 3'h7;
    localparam logic [2:0] ATT_SMALLEST   = 3'h6;
    localparam logic [2:0] ATT_RESERVED   = 3'h7;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h4;
    localparam logic [3:0]  REG_SYNC_CNT   = 4'h8;
    localparam int          CTRL_SW_EN_BIT = 0;
    localparam int          CTRL_MODE_LSB  = 4;
    localparam int          CTRL_ATT_LSB   = 8;
    localparam logic [10:0] CTRL_RESET     = 11'h000;
    localparam int          ST_PD_BIT      = 0;
    localparam int          ST_STATE_LSB   = 1;
    localparam int          ST_PATH_LSB    = 4;
    localparam int          ST_MODE_LSB    = 10;
    localparam int          ST_ATT_LSB     = 13;
    localparam int          ST_ATT_RSV_BIT = 16;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_POWER_DOWN,
        ST_SLEEP,
        ST_AC,
        ST_DC
    } tdc_state_type;

    typedef struct packed {
        logic out_en;
        logic buf_en;
        logic ac_diff;
        logic ac_common;
        logic dc_common;
        logic dc_diff;
    } tdc_path_type;

    // output enables and path selects for a mode code, attenuation code
    function automatic tdc_path_type decode_path(input logic [2:0] mode,
                                                 input logic [2:0] attenuation_select,
                                                 input logic       pd);
        tdc_path_type p;
        p = '0;
        if (!pd) begin
            case (mode)
                MODE_AC_BOTH: begin
                    p.out_en  = 1'b1;
                    p.buf_en  = 1'b1;
                    p.ac_diff = 1'b1;
                end
                MODE_AC_OUT: begin
                    p.out_en  = 1'b1;
                    p.ac_diff = 1'b1;
                end
                MODE_AC_BUF: begin
                    p.buf_en  = 1'b1;
                    p.ac_diff = 1'b1;
                end
                MODE_DC_COMMON: begin
                    p.out_en    = 1'b1;
                    p.buf_en    = 1'b1;
                    p.dc_common = 1'b1;
                end
                MODE_DC_DIFF: begin
                    p.out_en  = 1'b1;
                    p.buf_en  = 1'b1;
                    p.dc_diff = 1'b1;
                end
                MODE_AC_COMMON: begin
                    p.out_en    = 1'b1;
                    p.buf_en    = 1'b1;
                    // the attenuator leaves nothing at its smallest step
                    p.ac_common = (attenuation_select != ATT_SMALLEST);
                end
                default: begin
                    p = '0;
                end
            endcase
        end
        return p;
    endfunction

endpackage

// ===== hw/tdc_edge_det.sv
// rising edge detector for a pin sampled on the system clock
`timescale 1ns/100ps
`default_nettype none

module tdc_edge_det (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // level in, edge out
    input  wire logic level_i,
    output logic      rise_o
);

    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = level_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign rise_o = level_i & ~prev_q;

endmodule

`default_nettype wire

// ===== hw/tdc_ctrl.sv
// mode decode, loss of clock and sync divider for the test dac
//
// How it works
// - mode 6 gives ac common signal from bitstream, both output pairs on
// - ac common mode gives no waveform at attenuation 1/64
// - mode 4 drives dc common level, both pairs enabled
// - mode 5 drives dc differential level, both pairs enabled
// - leaving mode 5 for sleep turns driven pairs to high impedance
// - bitstream is one-bit data at nominal 256 khz
// - about 40 us without master clock edge enters power down
// - sync rising edge resets master clock counter and divider
// - attenuation code uses amplifier gain encoding, shared lines
// - mode codes: 0,7 sleep; 1-3 ac; 4,5 dc; 6 ac common
// - power down overrides pins; all pairs high impedance
// - attenuation 0 to 6 binary weighted, 7 reserved
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module tdc_ctrl (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [3:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // controller pins
    input  wire logic                  mclk_i,
    input  wire logic                  sample_sync_in_i,
    input  wire logic                  tdata_i,
    input  wire logic [2:0]            mode_i,
    input  wire logic [2:0]            attenuation_select_i,
    // analog side controls
    output tdc_pkg::tdc_path_type      path_o,
    output logic      [2:0]            att_code_o,
    output logic                       dac_bit_o,
    output logic                       bit_strobe_o,
    output logic                       power_down_o,
    output logic                       sleep_o
);

    // ****************************************************************
    // edges of master clock and sync
    // ****************************************************************
    logic mclk_rise;
    logic sync_rise;

    tdc_edge_det u_mclk_edge (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i (mclk_i),
        .rise_o  (mclk_rise)
    );

    tdc_edge_det u_sync_edge (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i (sample_sync_in_i),
        .rise_o  (sync_rise)
    );

    // ****************************************************************
    // control register
    // ****************************************************************
    logic [10:0] ctrl_q;
    logic [10:0] ctrl_d;
    logic [2:0]  src_mode;
    logic [2:0]  src_att;

    assign src_mode = ctrl_q[tdc_pkg::CTRL_SW_EN_BIT] ?
                      ctrl_q[tdc_pkg::CTRL_MODE_LSB +: 3] : mode_i;
    assign src_att  = ctrl_q[tdc_pkg::CTRL_SW_EN_BIT] ?
                      ctrl_q[tdc_pkg::CTRL_ATT_LSB +: 3] :
                      attenuation_select_i;

    // ****************************************************************
    // master clock domain logic, run from system clock samples
    // ****************************************************************
    logic [tdc_pkg::LOSS_W-1:0] loss_q, loss_d;
    logic                       pd_q, pd_d;
    logic [tdc_pkg::DIV_W-1:0]  div_q, div_d;
    logic [2:0]                 mode_s1_q, mode_s1_d, mode_q, mode_d;
    logic [2:0]                 att_s1_q, att_s1_d, att_q, att_d;
    logic                       bit_q, bit_d;
    logic                       strobe_q, strobe_d;
    logic [15:0]                sync_cnt_q, sync_cnt_d;

    localparam logic [tdc_pkg::LOSS_W-1:0] LOSS_LAST =
        tdc_pkg::LOSS_W'(tdc_pkg::LOSS_CYCLES - 1);
    localparam logic [tdc_pkg::DIV_W-1:0] DIV_LAST =
        tdc_pkg::DIV_W'(tdc_pkg::DIV_RATIO - 1);

    always_comb begin
        loss_d     = loss_q;
        pd_d       = pd_q;
        div_d      = div_q;
        mode_s1_d  = mode_s1_q;
        mode_d     = mode_q;
        att_s1_d   = att_s1_q;
        att_d      = att_q;
        bit_d      = bit_q;
        strobe_d   = 1'b0;
        sync_cnt_d = sync_cnt_q;
        if (mclk_rise) begin
            loss_d    = '0;
            pd_d      = 1'b0;
            mode_s1_d = src_mode;
            mode_d    = mode_s1_q;
            att_s1_d  = src_att;
            att_d     = att_s1_q;
            div_d     = div_q + 1'b1;
            if (div_q == DIV_LAST) begin
                bit_d    = tdata_i;
                strobe_d = 1'b1;
            end
        end else if (loss_q == LOSS_LAST) begin
            pd_d = 1'b1;
        end else begin
            loss_d = loss_q + 1'b1;
        end
        if (sync_rise) begin
            div_d      = '0;
            strobe_d   = 1'b0;
            sync_cnt_d = sync_cnt_q + 16'h0001;
        end
    end

    // ****************************************************************
    // state and output path decode
    // ****************************************************************
    tdc_pkg::tdc_state_type state_q, state_d;
    tdc_pkg::tdc_path_type  path_q, path_d;

    always_comb begin
        path_d = tdc_pkg::decode_path(mode_q, att_q, pd_q);
        if (pd_q) begin
            state_d = tdc_pkg::ST_POWER_DOWN;
        end else begin
            case (mode_q)
                tdc_pkg::MODE_SLEEP_LO,
                tdc_pkg::MODE_SLEEP_HI: state_d = tdc_pkg::ST_SLEEP;
                tdc_pkg::MODE_DC_COMMON,
                tdc_pkg::MODE_DC_DIFF:  state_d = tdc_pkg::ST_DC;
                default:                state_d = tdc_pkg::ST_AC;
            endcase
        end
    end

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic        req;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;

    always_comb begin
        ack_d  = req;
        rdat_d = rdat_q;
        ctrl_d = ctrl_q;
        if (req) begin
            rdat_d = 32'h0000_0000;
            if (wb_adr_i == tdc_pkg::REG_CTRL) begin
                rdat_d[10:0] = ctrl_q;
                if (wb_we_i && wb_sel_i[0]) begin
                    ctrl_d[7:0] = wb_dat_i[7:0];
                end
                if (wb_we_i && wb_sel_i[1]) begin
                    ctrl_d[10:8] = wb_dat_i[10:8];
                end
            end else if (wb_adr_i == tdc_pkg::REG_STATUS) begin
                rdat_d[tdc_pkg::ST_PD_BIT]         = pd_q;
                rdat_d[tdc_pkg::ST_STATE_LSB +: 2] = state_q;
                rdat_d[tdc_pkg::ST_PATH_LSB +: 6]  = path_q;
                rdat_d[tdc_pkg::ST_MODE_LSB +: 3]  = mode_q;
                rdat_d[tdc_pkg::ST_ATT_LSB +: 3]   = att_q;
                rdat_d[tdc_pkg::ST_ATT_RSV_BIT]    =
                    (att_q == tdc_pkg::ATT_RESERVED);
            end else if (wb_adr_i == tdc_pkg::REG_SYNC_CNT) begin
                rdat_d[15:0] = sync_cnt_q;
            end else begin
                rdat_d = 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // no master clock yet, so start powered down
            loss_q     <= LOSS_LAST;
            pd_q       <= 1'b1;
            div_q      <= '0;
            mode_s1_q  <= 3'h0;
            mode_q     <= 3'h0;
            att_s1_q   <= 3'h0;
            att_q      <= 3'h0;
            bit_q      <= 1'b0;
            strobe_q   <= 1'b0;
            sync_cnt_q <= 16'h0000;
            state_q    <= tdc_pkg::ST_POWER_DOWN;
            path_q     <= '0;
            ack_q      <= 1'b0;
            rdat_q     <= 32'h0000_0000;
            ctrl_q     <= tdc_pkg::CTRL_RESET;
        end else begin
            loss_q     <= loss_d;
            pd_q       <= pd_d;
            div_q      <= div_d;
            mode_s1_q  <= mode_s1_d;
            mode_q     <= mode_d;
            att_s1_q   <= att_s1_d;
            att_q      <= att_d;
            bit_q      <= bit_d;
            strobe_q   <= strobe_d;
            sync_cnt_q <= sync_cnt_d;
            state_q    <= state_d;
            path_q     <= path_d;
            ack_q      <= ack_d;
            rdat_q     <= rdat_d;
            ctrl_q     <= ctrl_d;
        end
    end

    assign path_o       = path_q;
    assign att_code_o   = att_q;
    assign dac_bit_o    = bit_q & (path_q.ac_diff | path_q.ac_common);
    assign bit_strobe_o = strobe_q;
    assign power_down_o = (state_q == tdc_pkg::ST_POWER_DOWN);
    assign sleep_o      = (state_q == tdc_pkg::ST_SLEEP);
    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = rdat_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_loss_enters_pd: assert property (@(posedge clk_i) disable iff (rst_i)
        (loss_q == LOSS_LAST && !mclk_rise) |=> ##1 power_down_o)
        else $error("no power down after master clock loss");
    a_mclk_clears_loss: assert property (@(posedge clk_i) disable iff (rst_i)
        mclk_rise |=> (loss_q == '0) && !pd_q)
        else $error("master clock edge did not clear loss counter");
    a_pd_outputs_off: assert property (@(posedge clk_i) disable iff (rst_i)
        power_down_o |-> (path_o == '0) && !dac_bit_o)
        else $error("output pair enabled in power down");
    a_ac_common_on: assert property (@(posedge clk_i) disable iff (rst_i)
        (!pd_q && mode_q == tdc_pkg::MODE_AC_COMMON &&
         att_q != tdc_pkg::ATT_SMALLEST)
        |=> path_o.out_en && path_o.buf_en && path_o.ac_common)
        else $error("mode 6 path wrong");
    a_ac_common_att: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_q == tdc_pkg::MODE_AC_COMMON && att_q == tdc_pkg::ATT_SMALLEST)
        |=> !path_o.ac_common)
        else $error("common waveform at smallest attenuation");
    a_dc_common_on: assert property (@(posedge clk_i) disable iff (rst_i)
        (!pd_q && mode_q == tdc_pkg::MODE_DC_COMMON)
        |=> path_o.out_en && path_o.buf_en && path_o.dc_common && sleep_o == 0)
        else $error("mode 4 path wrong");
    a_dc_diff_on: assert property (@(posedge clk_i) disable iff (rst_i)
        (!pd_q && mode_q == tdc_pkg::MODE_DC_DIFF)
        |=> path_o.out_en && path_o.buf_en && path_o.dc_diff)
        else $error("mode 5 path wrong");
    a_diff_to_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
        (path_o.dc_diff && (mode_q == tdc_pkg::MODE_SLEEP_LO ||
                            mode_q == tdc_pkg::MODE_SLEEP_HI))
        |=> path_o == '0 && (power_down_o || sleep_o))
        else $error("dc differential did not release to high impedance");
    a_sync_resets_div: assert property (@(posedge clk_i) disable iff (rst_i)
        sync_rise |=> div_q == '0 && !bit_strobe_o)
        else $error("sync edge did not reset divider");
    a_bit_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        bit_strobe_o |-> $past(mclk_rise) && $past(div_q) == DIV_LAST)
        else $error("bitstream sampled off the divider boundary");
    a_mode_two_stage: assert property (@(posedge clk_i) disable iff (rst_i)
        mclk_rise |=> mode_q == $past(mode_s1_q) &&
                      mode_s1_q == $past(src_mode))
        else $error("mode code skipped a synchroniser stage");

endmodule

`default_nettype wire

// ===== tb/tdc_ctl_model.sv
// controller model: master clock, sync and test bitstream
`timescale 1ns/100ps
`default_nettype none

module tdc_ctl_model (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // bench controls
    input  wire logic mclk_en_i,
    input  wire logic sys_sync_i,
    // device pins
    output logic      mclk_o,
    output logic      sync_o,
    output logic      tdata_o
);
    // 12 clocks a period: near 2.048 mhz, safely below clk/2
    logic [2:0] ph_q;
    logic [2:0] nr_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !mclk_en_i) begin
            ph_q   <= 3'h0;
            mclk_o <= 1'b0;
        end else if (ph_q == 3'h5) begin
            ph_q   <= 3'h0;
            mclk_o <= ~mclk_o;
        end else begin
            ph_q <= ph_q + 3'h1;
        end
    end
    // bits change on a fall so they stand still at every rise
    // sync never touches nr_q, so generator phase is not realigned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nr_q    <= 3'h0;
            tdata_o <= 1'b0;
        end else if (mclk_en_i && ph_q == 3'h5 && mclk_o) begin
            nr_q <= nr_q + 3'h1;
            // alternating bits: half density, mid-scale, no tone
            // no impulse content, so the generator gain limit always holds
            if (nr_q == 3'h7) tdata_o <= ~tdata_o;
        end
    end
    // sync off after reset, then follows the system sync input
    // one clock of delay, well inside one master clock period
    always_ff @(posedge clk_i) sync_o <= !rst_i && sys_sync_i;
endmodule
`default_nettype wire

// ===== tb/tdc_ctrl_tb.sv
// self-checking bench for the test dac control block
`timescale 1ns/100ps
`default_nettype none

module tdc_ctrl_tb;
    // ****************************************************************
    // signals
    // ****************************************************************
    localparam logic [7:0] OUT_M = 8'h76;
    localparam logic [7:0] BUF_M = 8'h7a;
    localparam logic [7:0] ACD_M = 8'h0e;
    localparam int         L     = tdc_pkg::LOSS_CYCLES;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic mclk_en = 1'b0, sys_sync = 1'b0, prev;
    logic [3:0] sel = 4'h0, adr = 4'h0;
    logic [2:0] mode = 3'h0, attenuation_select = 3'h0, att_code;
    logic [31:0] wdat = 32'h0, rdat, q, cnt;
    logic ack, mclk, sync, tdata, dac_bit, strobe, pd, slp;
    tdc_pkg::tdc_path_type path;
    int errors = 0, total_checks = 0, n, k;

    always #20 clk_i = ~clk_i;

    tdc_ctl_model MODEL (.clk_i(clk_i), .rst_i(rst_i), .mclk_en_i(mclk_en),
        .sys_sync_i(sys_sync), .mclk_o(mclk), .sync_o(sync),
        .tdata_o(tdata));
    tdc_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mclk_i(mclk),
        .sample_sync_in_i(sync), .tdata_i(tdata), .mode_i(mode),
        .attenuation_select_i(attenuation_select), .path_o(path), .att_code_o(att_code),
        .dac_bit_o(dac_bit), .bit_strobe_o(strobe), .power_down_o(pd),
        .sleep_o(slp));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic give_up(input string what);
        errors++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        wrap_up();
    endtask
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask
    // one classic cycle; the answer is taken at the edge ack is seen
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1) give_up("wishbone ack");
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rises(input int r);
        int i, s;
        logic p;
        s = 0;
        p = mclk;
        for (i = 0; i < 40 * r && s < r; i++) begin
            @(posedge clk_i);
            if (mclk === 1'b1 && p === 1'b0) s++;
            p = mclk;
        end
        if (s < r) give_up("master clock rise");
    endtask
    task automatic strobe_wait(output int c);
        for (c = 1; c < 400; c++) begin
            @(posedge clk_i);
            if (strobe === 1'b1) return;
        end
        give_up("bit strobe");
    endtask
    function automatic tdc_pkg::tdc_path_type exp_path(input logic [2:0] m,
                                                        input logic [2:0] a);
        tdc_pkg::tdc_path_type p;
        p.out_en    = OUT_M[m];
        p.buf_en    = BUF_M[m];
        p.ac_diff   = ACD_M[m];
        p.ac_common = (m == 3'h6) && (a != 3'h6);
        p.dc_common = (m == 3'h4);
        p.dc_diff   = (m == 3'h5);
        return p;
    endfunction
    // new pins show after two master clock rises and one clock
    task automatic pins(input logic [2:0] m, input logic [2:0] a);
        mode <= m;
        attenuation_select <= a;
        rises(3);
        repeat (2) @(posedge clk_i);
        check("path", {26'h0, path}, {26'h0, exp_path(m, a)});
        check("att code", {29'h0, att_code}, {29'h0, a});
    endtask

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("power down", {31'h0, pd}, 32'h1);
        check("path", {26'h0, path}, 32'h0);
        wb(1'b0, tdc_pkg::REG_CTRL, 32'h0);
        check("ctrl reset", q, {21'h0, tdc_pkg::CTRL_RESET});
        wb(1'b0, tdc_pkg::REG_STATUS, 32'h0);
        check("status pd", {29'h0, q[2:0]}, 32'h1);
        done("reset");
        mclk_en <= 1'b1;
        rises(2);
        repeat (3) @(posedge clk_i);
        check("power down", {31'h0, pd}, 32'h0);
        for (int m = 0; m < 8; m++) begin
            pins(m[2:0], 3'h0);
            check("sleep", {31'h0, slp}, {31'h0, m == 0 || m == 7});
        end
        for (int a = 0; a < 8; a++) pins(3'h6, a[2:0]);
        wb(1'b0, tdc_pkg::REG_STATUS, 32'h0);
        check("att reserved", {28'h0, q[16:13]}, 32'hf);
        done("mode and attenuation");
        // dc pulse straight on the mode pins, no register write between
        pins(3'h4, 3'h2);
        pins(3'h5, 3'h2);
        pins(3'h7, 3'h2);
        mode <= 3'h2;
        rises(1);
        repeat (2) @(posedge clk_i);
        check("early path", {26'h0, path}, 32'h0);
        done("leave dc and staging");
        pins(3'h1, 3'h0);
        strobe_wait(n);
        strobe_wait(n);
        check("bit period", n, tdc_pkg::DIV_RATIO * 12);
        check("dac bit", {31'h0, dac_bit}, {31'h0, tdata});
        pins(3'h4, 3'h0);
        strobe_wait(n);
        check("dc bit gated", {31'h0, dac_bit}, 32'h0);
        done("bitstream");
        wb(1'b0, tdc_pkg::REG_SYNC_CNT, 32'h0);
        cnt = q;
        rises(1);
        // sync lands mid low phase, away from any master clock rise
        repeat (7) @(posedge clk_i);
        sys_sync <= 1'b1;
        k = 0;
        prev = mclk;
        for (n = 0; n < 400 && strobe !== 1'b1; n++) begin
            @(posedge clk_i);
            if (mclk === 1'b1 && prev === 1'b0) k++;
            prev = mclk;
        end
        check("rises to bit", k, 8);
        sys_sync <= 1'b0;
        wb(1'b0, tdc_pkg::REG_SYNC_CNT, 32'h0);
        check("sync count", {16'h0, q[15:0]}, {16'h0, cnt[15:0] + 16'h1});
        done("sync");
        wb(1'b1, tdc_pkg::REG_CTRL, 32'h0000_0351);
        wb(1'b0, tdc_pkg::REG_CTRL, 32'h0);
        check("ctrl", q, 32'h0000_0351);
        rises(3);
        repeat (2) @(posedge clk_i);
        check("override", {26'h0, path}, {26'h0, exp_path(3'h5, 3'h3)});
        wb(1'b0, 4'hc, 32'h0);
        check("unmapped", q, 32'h0);
        wb(1'b1, tdc_pkg::REG_CTRL, 32'h0);
        done("registers");
        pins(3'h4, 3'h0);
        mclk_en <= 1'b0;
        for (n = 0; n < 1200 && pd !== 1'b1; n++) @(posedge clk_i);
        check("loss time", {31'h0, n >= L - 14 && n <= L + 4}, 32'h1);
        mode <= 3'h1;
        repeat (20) @(posedge clk_i);
        check("pd path", {26'h0, path}, 32'h0);
        // recovery order: sleep, restart the clock, then ac again
        mode <= 3'h0;
        mclk_en <= 1'b1;
        rises(2);
        pins(3'h1, 3'h0);
        check("pd exit", {31'h0, pd}, 32'h0);
        done("loss of clock");
        wrap_up();
    end
endmodule
`default_nettype wire
